// *** rtl/ostpg_regs.svh ***
// Register offsets, field positions, reset values and mode codes of the one-shot timer
`ifndef OSTPG_REGS_SVH
`define OSTPG_REGS_SVH

`define OSTPG_OFF_COUNT      8'h00
`define OSTPG_OFF_PERIOD     8'h04
`define OSTPG_OFF_RUNSCALE   8'h08
`define OSTPG_OFF_MODESYNC   8'h0c
`define OSTPG_OFF_CLKSEL     8'h10
`define OSTPG_OFF_RSTSEL     8'h14
`define OSTPG_OFF_PWCOMP     8'h18
`define OSTPG_OFF_STATUS     8'h1c

`define OSTPG_RUN_BIT        7
`define OSTPG_PRESCALE_HI    6
`define OSTPG_PRESCALE_LO    4
`define OSTPG_POSTSCALE_HI   3
`define OSTPG_POSTSCALE_LO   0
`define OSTPG_PSYNC_BIT      7
`define OSTPG_CPOL_BIT       6
`define OSTPG_CSYNC_BIT      5
`define OSTPG_MODE_HI        4
`define OSTPG_MODE_LO        0
`define OSTPG_SEL_HI         3
`define OSTPG_SEL_LO         0
`define OSTPG_ST_PULSE_BIT   0
`define OSTPG_ST_ACTIVE_BIT  1

`define OSTPG_MODE_ONESHOT   5'h08
`define OSTPG_RST_COUNT      8'h00
`define OSTPG_RST_PERIOD     8'hff
`define OSTPG_RST_CTRL       8'h00
`define OSTPG_RST_PWCOMP     8'h00

`endif

// *** rtl/ostpg_pkg.sv ***
// Types shared by the one-shot timer and pulse gate
package ostpg_pkg;

  typedef enum logic [1:0] {
    OSTPG_IDLE   = 2'b01,
    OSTPG_ACTIVE = 2'b10
  } ostpg_phase_type;

  typedef struct packed {
    ostpg_phase_type phase;
    logic [7:0]      count;
    logic [7:0]      period;
    logic            run;
    logic [2:0]      prescale;
    logic [3:0]      postscale;
    logic            psync;
    logic            cpol;
    logic            csync;
    logic [4:0]      mode;
    logic [3:0]      clk_src;
    logic [3:0]      rst_src;
    logic [7:0]      pw_comp;
    logic [6:0]      pre_cnt;
    logic            width_done;
    logic            pulse;
    logic            ack;
    logic [31:0]     rdata;
  } ostpg_state_type;

endpackage

// *** rtl/ostpg_top.sv ***
// One-shot period timer with pulse-width gate, Wishbone classic register slave
`timescale 1ns/1ps
`default_nettype none
`include "ostpg_regs.svh"

module ostpg_top #(
  parameter int CNT_W = 8
) (
  input  wire logic        clk_i,   // System and timer clock, 100 MHz
  input  wire logic        rst_i,   // Synchronous reset, active high
  input  wire logic        cyc_i,   // Wishbone cycle
  input  wire logic        stb_i,   // Wishbone strobe
  input  wire logic        we_i,    // Wishbone write enable
  input  wire logic [7:0]  adr_i,   // Wishbone byte address
  input  wire logic [3:0]  sel_i,   // Wishbone byte selects
  input  wire logic [31:0] dat_i,   // Wishbone write data
  output logic      [31:0] dat_o,   // Wishbone read data
  output logic             ack_o,   // Wishbone acknowledge
  output logic             pulse_o  // Pulse-width output
);

  // Count, period and compare fields are fixed at one byte
  if (CNT_W != 8) begin : g_width_check
    $error("ostpg_top: only an 8-bit counter is supported");
  end

  ostpg_pkg::ostpg_state_type s_q;
  ostpg_pkg::ostpg_state_type s_d;

  logic       req;
  logic       wr_now;
  logic       tick;
  logic       oneshot;
  logic       per_match;
  logic [6:0] pre_top;
  logic [7:0] rd_val;
  logic [7:0] wbyte;

  assign req     = cyc_i & stb_i;
  // Writes commit on the edge that the master sees ack, so data and ack line up
  assign wr_now  = req & we_i & s_q.ack & sel_i[0];
  assign wbyte   = dat_i[7:0];
  assign oneshot = (s_q.mode == `OSTPG_MODE_ONESHOT);
  assign pre_top = 7'((8'h01 << s_q.prescale) - 8'h01);
  assign tick    = s_q.run && (s_q.pre_cnt == pre_top);
  assign per_match = (s_q.count == s_q.period);

  always_comb begin
    rd_val = 8'h00;
    if (adr_i == `OSTPG_OFF_COUNT) begin
      rd_val = s_q.count;
    end else if (adr_i == `OSTPG_OFF_PERIOD) begin
      rd_val = s_q.period;
    end else if (adr_i == `OSTPG_OFF_RUNSCALE) begin
      rd_val = {s_q.run, s_q.prescale, s_q.postscale};
    end else if (adr_i == `OSTPG_OFF_MODESYNC) begin
      rd_val = {s_q.psync, s_q.cpol, s_q.csync, s_q.mode};
    end else if (adr_i == `OSTPG_OFF_CLKSEL) begin
      rd_val = {4'h0, s_q.clk_src};
    end else if (adr_i == `OSTPG_OFF_RSTSEL) begin
      rd_val = {4'h0, s_q.rst_src};
    end else if (adr_i == `OSTPG_OFF_PWCOMP) begin
      rd_val = s_q.pw_comp;
    end else if (adr_i == `OSTPG_OFF_STATUS) begin
      rd_val = {6'h00, s_q.phase == ostpg_pkg::OSTPG_ACTIVE, s_q.pulse};
    end
  end

  always_comb begin
    s_d = s_q;

    // Bus slave: one wait state, unmapped addresses answer with zero
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdata = {24'h000000, rd_val};
    end

    // Counting; the prescaler only advances while running
    if (s_q.run) begin
      s_d.pre_cnt = tick ? 7'h00 : 7'(s_q.pre_cnt + 7'h01);
    end
    case (s_q.phase)
      ostpg_pkg::OSTPG_IDLE: begin
        s_d.pulse = 1'b0;
        if (s_q.run && !oneshot && tick) begin
          s_d.count = per_match ? 8'h00 : 8'(s_q.count + 8'h01);
        end
      end
      ostpg_pkg::OSTPG_ACTIVE: begin
        if (tick) begin
          if (per_match) begin
            s_d.count = 8'h00;
            s_d.run   = 1'b0;
            s_d.phase = ostpg_pkg::OSTPG_IDLE;
            s_d.pulse = 1'b0;
          end else begin
            s_d.count = 8'(s_q.count + 8'h01);
          end
        end
        if (s_q.run && s_q.count == s_q.pw_comp) begin
          s_d.width_done = 1'b1;
        end
      end
      default: begin
        s_d.phase = ostpg_pkg::OSTPG_IDLE;
      end
    endcase

    // Software writes win over the hardware clear of run in the same edge
    if (wr_now) begin
      if (adr_i == `OSTPG_OFF_COUNT) begin
        s_d.count = wbyte;
      end else if (adr_i == `OSTPG_OFF_PERIOD) begin
        s_d.period = wbyte;
      end else if (adr_i == `OSTPG_OFF_RUNSCALE) begin
        s_d.run       = wbyte[`OSTPG_RUN_BIT];
        s_d.prescale  = wbyte[`OSTPG_PRESCALE_HI:`OSTPG_PRESCALE_LO];
        s_d.postscale = wbyte[`OSTPG_POSTSCALE_HI:`OSTPG_POSTSCALE_LO];
      end else if (adr_i == `OSTPG_OFF_MODESYNC) begin
        s_d.psync = wbyte[`OSTPG_PSYNC_BIT];
        s_d.cpol  = wbyte[`OSTPG_CPOL_BIT];
        s_d.csync = wbyte[`OSTPG_CSYNC_BIT];
        s_d.mode  = wbyte[`OSTPG_MODE_HI:`OSTPG_MODE_LO];
      end else if (adr_i == `OSTPG_OFF_CLKSEL) begin
        s_d.clk_src = wbyte[`OSTPG_SEL_HI:`OSTPG_SEL_LO];
      end else if (adr_i == `OSTPG_OFF_RSTSEL) begin
        s_d.rst_src = wbyte[`OSTPG_SEL_HI:`OSTPG_SEL_LO];
      end else if (adr_i == `OSTPG_OFF_PWCOMP) begin
        s_d.pw_comp = wbyte;
      end
    end

    // In one-shot mode a set of run from idle opens a fresh cycle; from active it only resumes
    if (s_d.run && oneshot && s_d.phase == ostpg_pkg::OSTPG_IDLE) begin
      s_d.phase      = ostpg_pkg::OSTPG_ACTIVE;
      s_d.width_done = 1'b0;
      s_d.pre_cnt    = 7'h00;
    end
    // Drive stays on while paused, so a pause stretches it by the stopped time
    if (s_d.phase == ostpg_pkg::OSTPG_ACTIVE) begin
      s_d.pulse = !s_d.run || !s_d.width_done;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.phase      <= ostpg_pkg::OSTPG_IDLE;
      s_q.count      <= `OSTPG_RST_COUNT;
      s_q.period     <= `OSTPG_RST_PERIOD;
      s_q.pw_comp    <= `OSTPG_RST_PWCOMP;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o   = s_q.rdata;
  assign ack_o   = s_q.ack;
  assign pulse_o = s_q.pulse;

  // Checks
  logic active;
  logic idle;
  assign active = (s_q.phase == ostpg_pkg::OSTPG_ACTIVE);
  assign idle   = (s_q.phase == ostpg_pkg::OSTPG_IDLE);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_match_event;
    active && s_q.run && tick && per_match && oneshot && !wr_now;
  endsequence

  sequence s_pause_then_resume;
    (active && !s_q.run && !wr_now) ##1 (active && !s_q.run && wr_now) ##1 (active && s_q.run);
  endsequence

  property p_period_match;
    s_match_event |=> (s_q.count == 8'h00) && !s_q.run && idle;
  endproperty
  a_period_match: assert property (p_period_match) else $error("period match did not stop the timer");

  property p_stay_stopped;
    idle && !s_q.run && !wr_now |=> !s_q.run && !pulse_o;
  endproperty
  a_stay_stopped: assert property (p_stay_stopped) else $error("timer restarted without software");

  property p_mode_gate;
    $rose(active) |-> oneshot;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("one-shot cycle began outside mode 01000");

  property p_pause_hold;
    active && !s_q.run && !wr_now |=> $stable(s_q.count) && active;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("count moved while paused");

  property p_resume_keeps_count;
    s_pause_then_resume |-> s_q.count == $past(s_q.count, 1);
  endproperty
  a_resume_keeps_count: assert property (p_resume_keeps_count) else $error("resume restarted the count");

  property p_pulse_start;
    idle ##1 (active && s_q.run) |-> pulse_o;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not raised with run");

  property p_pulse_end;
    active && s_q.run && (s_q.count == s_q.pw_comp) && !wr_now ##1 s_q.run |-> !pulse_o;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse not ended at width match");

  property p_pause_extends;
    active && !s_q.run |-> pulse_o;
  endproperty
  a_pause_extends: assert property (p_pause_extends) else $error("pulse dropped while paused");

  property p_idle_low;
    idle |-> !pulse_o;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("pulse high outside a cycle");

  property p_count_step;
    active && s_q.run && tick && !per_match && !wr_now |=> s_q.count == 8'($past(s_q.count) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one");

  property p_ack_one_cycle;
    req && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("bus answer not a single cycle");

  // Pause and resume after the width match, seen over two cycles
  sequence s_late_stop;
    (active && s_q.width_done && s_q.run) ##1 (active && !s_q.run);
  endsequence

  property p_late_pause;
    s_late_stop |-> pulse_o;
  endproperty
  a_late_pause: assert property (p_late_pause) else $error("pulse not extended by a late pause");

  property p_late_resume;
    active && s_q.width_done && s_q.run |-> !pulse_o;
  endproperty
  a_late_resume: assert property (p_late_resume) else $error("pulse high after width match while running");

  property p_run_needs_write;
    $rose(s_q.run) |-> $past(wr_now);
  endproperty
  a_run_needs_write: assert property (p_run_needs_write) else $error("run bit set without a bus write");

  property p_fresh_cycle;
    $rose(active) |-> s_q.run && !s_q.width_done && pulse_o;
  endproperty
  a_fresh_cycle: assert property (p_fresh_cycle) else $error("new cycle did not start clean");

  property p_other_mode_idle;
    idle && !oneshot && !wr_now |=> idle;
  endproperty
  a_other_mode_idle: assert property (p_other_mode_idle) else $error("cycle began outside one-shot mode");

  // Prescaled ticks: the count only moves on a tick
  property p_prescale_hold;
    active && s_q.run && !tick && !wr_now |=> $stable(s_q.count);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) else $error("count moved between ticks");

  property p_tick_spacing;
    tick && (s_q.prescale != 3'h0) && !wr_now |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("prescaled ticks too close");

  property p_width_mark;
    active && s_q.run && (s_q.count == s_q.pw_comp) && !wr_now |=> s_q.width_done;
  endproperty
  a_width_mark: assert property (p_width_mark) else $error("width match not recorded");

  property p_match_only_at_period;
    active && !(tick && per_match) && !wr_now |=> active;
  endproperty
  a_match_only_at_period: assert property (p_match_only_at_period) else $error("cycle ended early");

  // A pause must not disturb the width state, or the resume would misplace the pulse end
  property p_pause_no_width;
    active && !s_q.run |=> $stable(s_q.width_done);
  endproperty
  a_pause_no_width: assert property (p_pause_no_width) else $error("width state moved while paused");

  property p_idle_count_frozen;
    idle && oneshot && !wr_now |=> $stable(s_q.count);
  endproperty
  a_idle_count_frozen: assert property (p_idle_count_frozen) else $error("count moved after the cycle ended");

  // Register bus
  property p_no_ack_idle;
    !req |=> !ack_o;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle) else $error("answer without a request");

  property p_ack_answers;
    ack_o |-> $past(req) && !$past(ack_o);
  endproperty
  a_ack_answers: assert property (p_ack_answers) else $error("answer not tied to a request");

  property p_read_upper_zero;
    ack_o |-> dat_o[31:8] == 24'h000000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("read data upper bits not zero");

  property p_write_period;
    wr_now && (adr_i == `OSTPG_OFF_PERIOD) |=> s_q.period == $past(wbyte);
  endproperty
  a_write_period: assert property (p_write_period) else $error("period write did not land");

  property p_write_pwcomp;
    wr_now && (adr_i == `OSTPG_OFF_PWCOMP) |=> s_q.pw_comp == $past(wbyte);
  endproperty
  a_write_pwcomp: assert property (p_write_pwcomp) else $error("compare write did not land");

  // Software count writes win over a tick in the same edge
  property p_write_count;
    wr_now && (adr_i == `OSTPG_OFF_COUNT) |=> s_q.count == $past(wbyte);
  endproperty
  a_write_count: assert property (p_write_count) else $error("count write did not land");

  property p_masked_write;
    req && we_i && ack_o && !sel_i[0] |=> $stable(s_q.period) && $stable(s_q.pw_comp) && $stable(s_q.mode);
  endproperty
  a_masked_write: assert property (p_masked_write) else $error("masked write changed a register");

endmodule // ostpg_top
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the one-shot timer and pulse gate
`timescale 1ns/1ps
`default_nettype none
`include "ostpg_regs.svh"
module tb_top;
  localparam logic [7:0] CNT = `OSTPG_OFF_COUNT;
  localparam logic [7:0] PER = `OSTPG_OFF_PERIOD;
  localparam logic [7:0] RUN = `OSTPG_OFF_RUNSCALE;
  localparam logic [7:0] MOD = `OSTPG_OFF_MODESYNC;
  localparam logic [7:0] PWC = `OSTPG_OFF_PWCOMP;
  localparam logic [7:0] STS = `OSTPG_OFF_STATUS;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pulse_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, v1, v2, tmp;
  int          miscompares, checked;
  ostpg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pulse_o(pulse_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) miscompares++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1, tmp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 8'h00, 4'h1, r);
  endtask
  // Settle past the edge so registered outputs are read after they land
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pul(input string what, input logic e);
    chk(what, {31'h0, e}, {31'h0, pulse_o});
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(STS, v2);
      n++;
    end while (v2[1] !== 1'b0 && n < 40);
    chk("status", 32'h0, v2);
    rd(RUN, v2);
    chk("run bit", 32'h0, v2);
    step(8);
    pul("pulse idle", 1'b0);
    rd(CNT, v2);
    chk("count idle", 32'h0, v2);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      rd(8'(4 * i), v1);
      chk("reset value", (i == 1) ? 32'hff : 32'h0, v1);
    end
    wr(`OSTPG_OFF_CLKSEL, 8'hff);
    rd(`OSTPG_OFF_CLKSEL, v1);
    chk("clock source", 32'h0f, v1);
    wr(`OSTPG_OFF_RSTSEL, 8'hff);
    rd(`OSTPG_OFF_RSTSEL, v1);
    chk("reset select", 32'h0f, v1);
    bus(1'b1, PER, 8'h12, 4'h0, tmp);
    rd(PER, v1);
    chk("masked write", 32'hff, v1);
    wr(8'h20, 8'h55);
    rd(8'h20, v1);
    chk("unmapped", 32'h0, v1);
    wr(CNT, 8'h05);
    rd(CNT, v1);
    chk("count rw", 32'h05, v1);
    wr(CNT, 8'h00);
  endtask
  task automatic t_walk;
    wr(MOD, 8'h08);
    wr(PER, 8'h03);
    wr(PWC, 8'h01);
    wr(RUN, 8'h80);
    #1;
    for (int i = 0; i < 5; i++) begin
      pul("pulse walk", i < 2);
      step(1);
    end
    wait_done;
  endtask
  task automatic t_pause;
    wr(PER, 8'h0a);
    wr(PWC, 8'h06);
    wr(RUN, 8'h80);
    wr(RUN, 8'h00);
    rd(CNT, v1);
    step(5);
    rd(CNT, v2);
    chk("held count", v1, v2);
    pul("pulse paused", 1'b1);
    wr(RUN, 8'h80);
    rd(CNT, v2);
    chk("resumed", 32'h1, {31'h0, v2 > v1});
    wait_done;
  endtask
  task automatic t_late;
    wr(PER, 8'h14);
    wr(PWC, 8'h02);
    wr(RUN, 8'h80);
    step(6);
    pul("width match", 1'b0);
    wr(RUN, 8'h00);
    step(2);
    pul("late pause", 1'b1);
    wr(RUN, 8'h80);
    step(2);
    pul("late resume", 1'b0);
    wait_done;
  endtask
  // Other modes run freely and must not touch the pulse or the run bit
  task automatic t_mode;
    wr(MOD, 8'h00);
    wr(PER, 8'h03);
    wr(RUN, 8'h80);
    step(1);
    pul("other mode", 1'b0);
    step(12);
    rd(RUN, v1);
    chk("run kept", 32'h80, v1);
    wr(RUN, 8'h00);
    wr(MOD, 8'h08);
  endtask
  // Prescale 1 halves the tick rate, so the width match lands a clock later
  task automatic t_scale;
    wr(CNT, 8'h00);
    wr(PER, 8'h02);
    wr(PWC, 8'h01);
    wr(RUN, 8'h90);
    #1;
    pul("scaled start", 1'b1);
    step(2);
    pul("scaled hold", 1'b1);
    step(1);
    pul("scaled end", 1'b0);
    step(8);
    rd(RUN, v1);
    chk("scaled stop", 32'h10, v1);
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    miscompares = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_walk;
    t_pause;
    t_late;
    t_mode;
    t_scale;
    stop_test;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
